// ==== include/rbl_pkg.sv ====
// Purpose: Shared constants and types of the reset boot loader.
// Assumes: 200 MHz mclk, little-endian system byte order.
// Notes:   Timing counts derive from times in ns and the clock period.

package rbl_pkg;

  // ******************************************************
  // Boot image geometry
  // ******************************************************
  localparam int unsigned BOOT_BYTES = 1024;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned BOOT_WORDS = BOOT_BYTES / WORD_BYTES;
  localparam int unsigned ROM_AW     = $clog2(BOOT_BYTES);
  localparam int unsigned WR_AW      = $clog2(BOOT_WORDS);
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned ROM_DW     = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned HALF_W     = 16;
  localparam int unsigned FIFO_DEPTH = 16;

  // Start of the ROM chip-select space and destination of the copy
  localparam logic [ROM_AW-1:0] ROM_START   = 10'h000;
  localparam logic [WR_AW-1:0]  BOOT_DEST   = 8'h00;
  localparam logic [WR_AW-1:0]  LAST_IDX    = 8'hff;
  localparam logic [31:0]       BOOT_VECTOR = 32'h0000_0000;
  localparam logic [1:0]        LANE0       = 2'h0;

  // Address step per ROM read, by ROM width
  localparam logic [ROM_AW-1:0] STEP_B8  = 10'h001;
  localparam logic [ROM_AW-1:0] STEP_B16 = 10'h002;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned ROM_ACCESS_NS  = 40;
  localparam int unsigned ROM_ACCESS_CYC =
    (ROM_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACC_W          = 4;

  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic {RBL_MODE_EMU, RBL_MODE_ROM} rbl_mode_t;
  typedef enum logic {RBL_W8, RBL_W16} rbl_width_t;

  typedef struct packed {
    rbl_mode_t  mode;
    rbl_width_t width;
  } rbl_cfg_t;

endpackage : rbl_pkg

// ==== hdl/rbl_fifo.sv ====
// Purpose: Word FIFO between the ROM packer and the memory writer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Count-based full and empty; any depth of two or more.

`timescale 1ns/1ps
`default_nettype none

module rbl_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Wrap a pointer at the depth, not at a power of two
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  // Handshakes
  assign in_ready  = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  // Storage, no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule : rbl_fifo

`default_nettype wire

// ==== hdl/rbl_boot.sv ====
// Purpose: Boot sequencer run after reset: emulation boot or ROM copy.
// Assumes: ROM data valid at the end of a fixed strobe; memory accepts
//          one word per cycle while mem_wr_ready is high.
// Notes:   Processor stays stalled until the boot ends.

`timescale 1ns/1ps
`default_nettype none

module rbl_boot
  import rbl_pkg::*;
#(
  parameter int unsigned ACCESS_CYC = ROM_ACCESS_CYC,
  parameter int unsigned FIFO_D     = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Configuration straps
  input  wire rbl_cfg_t          cfg,
  // Debug emulator
  input  wire logic              emu_release,
  // ROM read side of the external memory port
  output logic                   rom_rd_en,
  output logic [ROM_AW-1:0]      rom_addr,
  input  wire logic [ROM_DW-1:0] rom_data,
  // Internal memory write side
  output logic                   mem_wr_en,
  output logic [WR_AW-1:0]       mem_wr_addr,
  output logic [WORD_W-1:0]      mem_wr_data,
  input  wire logic              mem_wr_ready,
  // Processor control
  output logic                   cpu_stall,
  output logic [31:0]            cpu_start_addr,
  output logic                   boot_done
);

  // ******************************************************
  // Types and signals
  // ******************************************************
  typedef enum logic [1:0] {ST_SAMPLE, ST_EMU, ST_COPY, ST_RUN} rbl_state_t;

  rbl_state_t        st_r;
  rbl_state_t        st_nxt;
  rbl_cfg_t          cfg_r;
  logic              stall_r;
  logic              busy_r;
  logic [ACC_W-1:0]  acc_r;
  logic [ROM_AW-1:0] addr_r;
  logic [ROM_AW-1:0] addr_nxt;
  logic [WORD_W-1:0] pack_r;
  logic              full_r;
  logic              rd_done_r;
  logic [WR_AW-1:0]  wr_idx_r;
  logic              samp;
  logic              fifo_in_rdy;
  logic              fifo_out_vld;
  logic              fifo_out_rdy;
  logic [WORD_W-1:0] fifo_out_data;
  logic              mem_fire;
  logic              copying;

  // ******************************************************
  // Helpers
  // ******************************************************

  // Address advance per ROM read
  function automatic logic [ROM_AW-1:0] rom_step(input rbl_width_t wd);
    return (wd == RBL_W16) ? STEP_B16 : STEP_B8;
  endfunction : rom_step

  // Drop one ROM read into its lane, lowest address in lowest bits
  function automatic logic [WORD_W-1:0] pack_ins(
    input logic [WORD_W-1:0] w,
    input logic [ROM_DW-1:0] d,
    input logic [1:0]        lane,
    input rbl_width_t        wd
  );
    logic [WORD_W-1:0] r;
    r = w;
    if (wd == RBL_W16) begin
      r[lane[1]*HALF_W +: HALF_W] = d;
    end else begin
      r[lane*BYTE_W +: BYTE_W] = d[BYTE_W-1:0];
    end
    return r;
  endfunction : pack_ins

  // ******************************************************
  // Boot sequence
  // ******************************************************

  // Mode choice happens once, in the first cycle after release
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_SAMPLE: begin
        st_nxt = (cfg.mode == RBL_MODE_ROM) ? ST_COPY : ST_EMU;
      end
      ST_EMU: begin
        if (emu_release) begin
          st_nxt = ST_RUN;
        end
      end
      ST_COPY: begin
        if (mem_fire && wr_idx_r == LAST_IDX) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        st_nxt = ST_RUN;
      end
      default: begin
        st_nxt = ST_SAMPLE;
      end
    endcase
  end

  // State register, parked in sample state while reset holds
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= ST_SAMPLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Straps caught by a clocked process after release, never by reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg_r <= '{mode: RBL_MODE_EMU, width: RBL_W8};
    end else if (st_r == ST_SAMPLE) begin
      cfg_r <= cfg;
    end
  end

  // Stall held from reset until the chosen boot finishes
  always_ff @(posedge mclk) begin
    if (rst) begin
      stall_r <= 1'b1;
    end else if (st_nxt == ST_RUN) begin
      stall_r <= 1'b0;
    end
  end

  assign cpu_stall      = stall_r;
  assign cpu_start_addr = BOOT_VECTOR;
  assign boot_done      = (st_r == ST_RUN);
  assign copying        = (st_r == ST_COPY);

  // ******************************************************
  // ROM reader and word packer
  // ******************************************************

  // Fixed-length strobe; a new one waits while a packed word is pending
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_r <= 1'b0;
      acc_r  <= '0;
    end else if (copying && !busy_r && !full_r && !rd_done_r) begin
      busy_r <= 1'b1;
      acc_r  <= ACC_W'(ACCESS_CYC - 1);
    end else if (samp) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      acc_r <= acc_r - 1'b1;
    end
  end

  // Data is taken on the last strobe cycle
  assign samp      = busy_r && (acc_r == '0);
  assign addr_nxt  = addr_r + rom_step(cfg_r.width);
  assign rom_rd_en = busy_r;
  assign rom_addr  = addr_r;

  // Lanes fill in address order; image is little endian like the system
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_r    <= ROM_START;
      pack_r    <= '0;
      rd_done_r <= 1'b0;
    end else if (samp) begin
      pack_r <= pack_ins(pack_r, rom_data, addr_r[1:0], cfg_r.width);
      addr_r <= addr_nxt;
      if (addr_nxt == ROM_START) begin
        rd_done_r <= 1'b1;
      end
    end
  end

  // Word is offered to the FIFO once its last lane is in
  always_ff @(posedge mclk) begin
    if (rst) begin
      full_r <= 1'b0;
    end else if (samp && addr_nxt[1:0] == LANE0) begin
      full_r <= 1'b1;
    end else if (full_r && fifo_in_rdy) begin
      full_r <= 1'b0;
    end
  end

  // ******************************************************
  // Word buffer and memory writer
  // ******************************************************

  // Decouples slow ROM strobes from a memory that may stall
  rbl_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_D)
  ) u_rbl_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (full_r),
    .in_ready  (fifo_in_rdy),
    .in_data   (pack_r),
    .out_valid (fifo_out_vld),
    .out_ready (fifo_out_rdy),
    .out_data  (fifo_out_data)
  );

  // Writes only happen during the copy, never in emulation boot
  assign fifo_out_rdy = copying && mem_wr_ready;
  assign mem_wr_en    = copying && fifo_out_vld;
  assign mem_fire     = mem_wr_en && mem_wr_ready;
  assign mem_wr_addr  = BOOT_DEST + wr_idx_r;
  assign mem_wr_data  = fifo_out_data;

  // Consecutive word index from the boot destination
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_idx_r <= '0;
    end else if (mem_fire) begin
      wr_idx_r <= wr_idx_r + 1'b1;
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  reset_hold_a: assert property (
    disable iff (1'b0) rst |=> (cpu_stall && !rom_rd_en && !mem_wr_en && st_r == ST_SAMPLE))
    else $error("boot logic left reset state during reset");

  mode_rom_a: assert property (
    (st_r == ST_SAMPLE && cfg.mode == RBL_MODE_ROM) |=> (st_r == ST_COPY) ##1 rom_rd_en)
    else $error("ROM boot did not start after release");

  mode_emu_a: assert property (
    (st_r == ST_SAMPLE && cfg.mode == RBL_MODE_EMU) |=> (st_r == ST_EMU && cpu_stall))
    else $error("emulation boot not entered");

  emu_quiet_a: assert property (
    (st_r == ST_EMU) |-> (!rom_rd_en && !mem_wr_en && cpu_stall))
    else $error("activity during emulation boot");

  emu_release_a: assert property (
    (st_r == ST_EMU && emu_release) |=> (!cpu_stall && boot_done && cpu_start_addr == '0))
    else $error("emulator release did not start processor");

  strobe_len_a: assert property (
    $rose(rom_rd_en) |-> (rom_rd_en && cpu_stall) [*8] ##1 !rom_rd_en)
    else $error("ROM strobe length wrong");

  addr_stable_a: assert property (
    (rom_rd_en && $past(rom_rd_en)) |-> $stable(rom_addr))
    else $error("ROM address moved during a strobe");

  pack_align_a: assert property (
    $rose(full_r) |-> (rom_addr[1:0] == LANE0 &&
      $past(rom_addr) == rom_addr - ((cfg_r.width == RBL_W16) ? STEP_B16 : STEP_B8)))
    else $error("word offered before all lanes filled");

  write_window_a: assert property (
    mem_wr_en |-> (copying && cfg_r.mode == RBL_MODE_ROM && cpu_stall))
    else $error("memory write outside ROM copy");

  copy_end_a: assert property (
    (mem_fire && mem_wr_addr == LAST_IDX) |=> (!cpu_stall && boot_done && !mem_wr_en))
    else $error("stall not released after last word");

  cfg_hold_a: assert property (
    (st_r != ST_SAMPLE) |=> $stable(cfg_r))
    else $error("boot settings changed after release");

endmodule : rbl_boot

`default_nettype wire

// ==== verification/rbl_rom_model.sv ====
// Purpose: Behavioural boot ROM on the external memory port.
// Assumes: Data is read while the read strobe is high.
// Notes:   A released bus shows the inverse of its last value.

`timescale 1ns/1ps
`default_nettype none

module rbl_rom_model
  import rbl_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Read side
  input  wire logic              rom_rd_en,
  input  wire logic [ROM_AW-1:0] rom_addr,
  input  wire rbl_width_t        width,
  output logic [ROM_DW-1:0]      rom_data
);
  logic [ROM_DW-1:0] last_r = '0;

  // Image byte at a byte address, stored little endian
  function automatic logic [7:0] img(input logic [ROM_AW-1:0] a);
    return a[7:0] ^ {a[9:8], 6'h15};
  endfunction : img

  // Drive while strobed; upper lane junk on a byte-wide part
  always_comb begin
    if (rom_rd_en) begin
      rom_data = (width == RBL_W16) ? {img(rom_addr + 10'h001), img(rom_addr)}
                                    : {~img(rom_addr), img(rom_addr)};
    end else begin
      rom_data = ~last_r;  // Released: toggles each cycle so stale reads show
    end
  end

  // Remember the last value on the lines
  always_ff @(posedge mclk) begin
    last_r <= rom_data;
  end
endmodule : rbl_rom_model

`default_nettype wire

// ==== verification/test_rbl_boot.sv ====
// Purpose: Self-checking bench of the reset boot loader.
// Assumes: Default strobe length and FIFO depth.
// Notes:   Memory write side is judged word by word.

`timescale 1ns/1ps
`default_nettype none

module test_rbl_boot;
  import rbl_pkg::*;

  logic              mclk;
  logic              rst;
  rbl_cfg_t          cfg;
  logic              emu_release;
  logic              rom_rd_en;
  logic [ROM_AW-1:0] rom_addr;
  logic [ROM_DW-1:0] rom_data;
  logic              mem_wr_en;
  logic [WR_AW-1:0]  mem_wr_addr;
  logic [WORD_W-1:0] mem_wr_data;
  logic              mem_wr_ready;
  logic              cpu_stall;
  logic [31:0]       cpu_start_addr;
  logic              boot_done;
  rbl_width_t        rom_width;
  int                failures = 0;
  int                tests_run = 0;
  int                cycles = 0;

  rbl_boot u_rbl_boot (.mclk(mclk), .rst(rst), .cfg(cfg), .emu_release(emu_release),
    .rom_rd_en(rom_rd_en), .rom_addr(rom_addr), .rom_data(rom_data), .mem_wr_en(mem_wr_en),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
    .cpu_stall(cpu_stall), .cpu_start_addr(cpu_start_addr), .boot_done(boot_done));

  rbl_rom_model u_rbl_rom_model (.mclk(mclk), .rom_rd_en(rom_rd_en), .rom_addr(rom_addr),
    .width(rom_width), .rom_data(rom_data));

  // Clock of 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  function automatic logic [7:0] img(input logic [ROM_AW-1:0] a);
    return a[7:0] ^ {a[9:8], 6'h15};
  endfunction : img

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // Reset with straps set; outputs judged while reset holds
  task automatic do_reset(input rbl_cfg_t c);
    @(posedge mclk);
    rst <= 1'b1;
    cfg <= c;
    rom_width <= c.width;
    emu_release <= 1'b0;
    mem_wr_ready <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check({cpu_stall, rom_rd_en, mem_wr_en, boot_done}, 32'h8);
    @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_emu;
    int i;
    do_reset('{RBL_MODE_EMU, RBL_W16});
    @(posedge mclk);
    cfg <= '{RBL_MODE_ROM, RBL_W8};  // Late strap change must be ignored
    mem_wr_ready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(negedge mclk);
      check({cpu_stall, rom_rd_en, mem_wr_en, boot_done}, 32'h8);
    end
    @(posedge mclk);
    emu_release <= 1'b1;  // Breakpoint at 0 taken as placed
    @(posedge mclk);
    emu_release <= 1'b0;
    @(negedge mclk);
    check({cpu_stall, boot_done}, 32'h1);
    check(cpu_start_addr, BOOT_VECTOR);
  endtask : test_emu

  // Copy run; a short limit aborts it by the next reset
  task automatic test_rom(input rbl_width_t w, input bit slow, input int limit);
    int k;
    int n;
    int last;
    logic [ROM_AW-1:0] a;
    do_reset('{RBL_MODE_ROM, w});
    k = 0;
    last = 0;
    for (n = 0; n < limit && !boot_done; n++) begin
      @(posedge mclk);
      mem_wr_ready <= slow ? (n > 800 && n[2]) : 1'b1;  // Long stall fills the FIFO
      emu_release <= n[3];  // Only honoured in emulation boot
      if (n == 1) begin
        // Straps flipped after capture; the ROM keeps its real width
        cfg <= '{RBL_MODE_EMU, (w == RBL_W8) ? RBL_W16 : RBL_W8};
      end
      @(negedge mclk);
      if (mem_wr_en && mem_wr_ready) begin
        a = 10'(k * 4);
        check(mem_wr_addr, k[7:0]);
        check(mem_wr_data, {img(a + 10'h003), img(a + 10'h002), img(a + 10'h001), img(a)});
        k++;
        last = n;
      end
    end
    if (limit > 1000) begin
      check(k, 32'h100);
      check(n - last, 32'h2);
      check({cpu_stall, boot_done, mem_wr_en}, 32'h2);
      check(cpu_start_addr, BOOT_VECTOR);
    end
  endtask : test_rom

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    cfg = '{RBL_MODE_EMU, RBL_W8};
    rom_width = RBL_W8;
    emu_release = 1'b0;
    mem_wr_ready = 1'b0;
    repeat (16) @(posedge mclk);
    test_emu();
    test_rom(RBL_W16, 1'b0, 300);
    test_rom(RBL_W8, 1'b1, 30000);
    test_rom(RBL_W16, 1'b0, 30000);
    end_of_test();
  end
endmodule : test_rbl_boot

`default_nettype wire
